// >>> verilog/flow_pkg.sv
package flow_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [3:0] OFS_OPT2 = 4'h0;
  localparam logic [3:0] OFS_OPT3 = 4'h1;
  localparam logic [3:0] OFS_SC1  = 4'h2;
  localparam logic [3:0] OFS_SC2  = 4'h3;
  localparam logic [3:0] OFS_SC3  = 4'h4;
  localparam logic [3:0] OFS_SC4  = 4'h5;
  localparam logic [3:0] OFS_FTHR = 4'h6;
  localparam logic [3:0] OFS_DTHR = 4'h7;
  localparam logic [3:0] OFS_SPECIAL_TX_COMMAND_REG = 4'h8;
  localparam logic [3:0] OFS_CSR  = 4'h9;
  localparam logic [3:0] OFS_RIS  = 4'ha;
  localparam logic [3:0] OFS_TPR  = 4'hb;
  localparam logic [3:0] OFS_CHN  = 4'hc;
  localparam logic [3:0] OFS_MSV  = 4'hd;
  localparam logic [3:0] OFS_DIV  = 4'he;

  // ==========================================================
  // Field positions
  localparam int OPT2_ANY     = 7;
  localparam int OPT2_INBAND  = 6;
  localparam int OPT2_ETC     = 5;
  localparam int OPT2_CTS     = 1;
  localparam int OPT2_SYNC    = 0;
  localparam int OPT3_DISCARD = 5;
  localparam int OPT3_DETECT  = 4;
  localparam int OPT3_SEVEN   = 0;
  localparam int SPECIAL_TX_COMMAND_REG_SEND    = 3;
  localparam int CSR_RXOFF    = 4;
  localparam int CSR_RXON     = 3;
  localparam int CSR_TXOFF    = 2;
  localparam int CSR_TXON     = 1;
  localparam int RIS_BREAK    = 0;
  localparam int CHN_TXEN     = 0;
  localparam int CHN_RXEN     = 1;
  localparam int CHN_RESET    = 2;
  localparam int MSV_RTS      = 0;
  localparam int MSV_DTR      = 1;
  localparam int MSV_CTS      = 2;
  localparam int MSV_DSR      = 3;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [7:0] RST_TPR = 8'h09;
  localparam logic       RST_PIN = 1'b1;

  // ==========================================================
  // Escape codes and character timing
  localparam logic [7:0]  ESC_LEAD    = 8'h00;
  localparam logic [7:0]  ESC_BRK_ON  = 8'h81;
  localparam logic [7:0]  ESC_DELAY   = 8'h82;
  localparam logic [7:0]  ESC_BRK_OFF = 8'h83;
  localparam logic [7:0]  ESC_NUL7    = 8'h80;
  localparam logic [15:0] CHAR_BITS_7 = 16'h0009;
  localparam logic [15:0] CHAR_BITS_8 = 16'h000a;
  localparam int unsigned CLK_MHZ         = 125;
  localparam int unsigned TICK_UNIT_US    = 100;
  localparam int unsigned TICK_CYCLES_DEF = TICK_UNIT_US * CLK_MHZ;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {ESC_IDLE, ESC_ZERO, ESC_COUNT} esc_type;

  typedef struct packed {
    logic       last;
    logic [7:0] data;
  } tx_byte_type;

  typedef struct packed {
    logic       err;
    logic [7:0] data;
  } rx_char_type;

  typedef struct packed {
    logic       exc;
    logic [7:0] data;
  } rx_out_type;

  typedef struct packed {
    logic [7:0] div;
    logic       seven;
  } ser_cfg_type;

endpackage : flow_pkg

// >>> verilog/char_shifter.sv
`timescale 1ns/1ns
module char_shifter (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // Line format
  input  wire flow_pkg::ser_cfg_type cfg,
  // Character load and break request
  input  wire logic                  brk_req,
  input  wire logic                  ld_valid,
  input  wire logic [7:0]            ld_data,
  // Status and line
  output logic                       ld_ready,
  output logic                       empty,
  output logic                       txd,
  output logic                       brk_line
);

  typedef struct packed {
    logic        full;
    logic [7:0]  hold;
    logic        busy;
    logic [9:0]  shreg;
    logic [3:0]  bitn;
    logic [11:0] tcnt;
    logic        txd;
    logic        brk;
  } shifter_type;

  shifter_type q;
  shifter_type n;
  logic [3:0]  last;
  logic [11:0] period;

  // ==========================================================
  // Holding register feeds shift register; start, data, stop
  always_comb begin
    n      = q;
    last   = cfg.seven ? 4'(flow_pkg::CHAR_BITS_7 - 16'h0001) : 4'(flow_pkg::CHAR_BITS_8 - 16'h0001);
    period = {cfg.div, 4'hf};
    if (q.busy) begin
      if (q.tcnt != 12'h000) begin
        n.tcnt = q.tcnt - 12'h001;
      end else if (q.bitn == last) begin
        n.busy = 1'b0;
      end else begin
        n.tcnt  = period;
        n.bitn  = q.bitn + 4'h1;
        n.shreg = {1'b1, q.shreg[9:1]};
        n.txd   = q.shreg[1];
      end
    end else if (q.full) begin
      // Queued character always beats a break request
      n.full  = 1'b0;
      n.busy  = 1'b1;
      n.shreg = cfg.seven ? {2'b11, q.hold[6:0], 1'b0} : {1'b1, q.hold, 1'b0};
      n.bitn  = 4'h0;
      n.tcnt  = period;
      n.txd   = 1'b0;
      n.brk   = 1'b0;
    end else begin
      n.txd = ~brk_req;
      n.brk = brk_req;
    end
    if (ld_valid && !q.full) begin
      n.full = 1'b1;
      n.hold = ld_data;
    end
    if (rst) begin
      n     = '0;
      n.txd = flow_pkg::RST_PIN;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    q <= n;
  end

  assign ld_ready = ~q.full;
  assign empty    = ~q.full & ~q.busy;
  assign txd      = q.txd;
  assign brk_line = q.brk;

endmodule : char_shifter

// >>> verilog/async_flow_control_and_break.sv
`timescale 1ns/1ns
module async_flow_control_and_break #(
  parameter int unsigned TICK_CYCLES = flow_pkg::TICK_CYCLES_DEF
) (
  // Clock and reset
  input  wire logic                  MCLK,
  input  wire logic                  SYS_RST,
  // Register port
  input  wire logic [3:0]            ADDR,
  input  wire logic [7:0]            WDATA,
  input  wire logic                  WR,
  input  wire logic                  RD,
  output logic [7:0]                 RDATA,
  // Transmit stream from host
  input  wire logic                  TX_VALID,
  input  wire flow_pkg::tx_byte_type TX_BYTE,
  output logic                       TX_READY,
  // Received characters and receive FIFO fill
  input  wire logic                  RX_CHAR_VALID,
  input  wire flow_pkg::rx_char_type RX_CHAR,
  input  wire logic [4:0]            RX_FIFO_LEVEL,
  output logic                       RX_OUT_VALID,
  output flow_pkg::rx_out_type       RX_OUT,
  // Line and modem pins
  input  wire logic                  RXD,
  input  wire logic                  CTS_N,
  input  wire logic                  DSR_N,
  output logic                       TXD,
  output logic                       RTS_N,
  output logic                       DTR_N
);

  typedef struct packed {
    logic [7:0]           opt2;
    logic [7:0]           opt3;
    logic [3:0][7:0]      sc;
    logic [3:0]           fthr;
    logic [3:0]           dthr;
    logic [3:0]           special_tx_command_reg;
    logic [7:0]           tick_prescaler;
    logic [7:0]           div;
    logic                 txen;
    logic                 rxen;
    logic                 msv_rts;
    logic                 msv_dtr;
    logic                 tx_stop;
    logic                 tx_resume;
    logic                 rx_stop;
    logic                 rx_resume;
    logic                 brk_stat;
    logic                 cts1;
    logic                 cts2;
    logic                 dsr1;
    logic                 dsr2;
    logic                 rxd1;
    logic                 rxd2;
    logic [15:0]          rxlow;
    logic                 dtr_n;
    logic                 rts_n;
    logic [7:0]           rdata;
    logic                 rxo_valid;
    flow_pkg::rx_out_type rxo;
    logic                 in_free;
    flow_pkg::tx_byte_type in_byte;
    flow_pkg::esc_type    esc;
    logic                 brk_req;
    logic [15:0]          brk_cnt;
    logic                 brk_done;
    logic [7:0]           delay;
    logic [7:0]           pre;
    logic [15:0]          unit;
    logic                 in_frame;
  } state_type;

  state_type             q;
  state_type             n;
  logic                  ld_valid;
  logic [7:0]            ld_data;
  logic                  ser_ready;
  logic                  ser_empty;
  logic                  ser_txd;
  logic                  ser_brk;
  flow_pkg::ser_cfg_type cfg;

  // ==========================================================
  // Character time in clocks; bit period is (div + 1) * 16
  function automatic logic [15:0] char_cycles(input logic [7:0] div, input logic seven);
    logic [15:0] per;
    per         = ({8'h00, div} + 16'h0001) << 4;
    char_cycles = per * (seven ? flow_pkg::CHAR_BITS_7 : flow_pkg::CHAR_BITS_8);
  endfunction : char_cycles

  // ==========================================================
  // Next state
  always_comb begin
    logic        is_flow;
    logic        det_on;
    logic        flow_ok;
    logic        cts_ok;
    logic        send_ok;
    logic        seven;
    logic [7:0]  b;
    logic [15:0] ct;
    n        = q;
    is_flow  = 1'b0;
    flow_ok  = 1'b0;
    cts_ok   = 1'b0;
    send_ok  = 1'b0;
    ld_valid = 1'b0;
    ld_data  = 8'h00;
    seven    = q.opt3[flow_pkg::OPT3_SEVEN];
    det_on   = q.opt3[flow_pkg::OPT3_DETECT] & q.opt2[flow_pkg::OPT2_INBAND];
    b        = q.in_byte.data;
    ct       = char_cycles(q.div, seven);

    // Pin synchronisers
    n.cts1 = CTS_N;
    n.cts2 = q.cts1;
    n.dsr1 = DSR_N;
    n.dsr2 = q.dsr1;
    n.rxd1 = RXD;
    n.rxd2 = q.rxd1;

    // Bus writes first, so hardware sets below win over clears
    if (WR) begin
      if (ADDR == flow_pkg::OFS_OPT2) begin
        n.opt2 = WDATA;
      end else if (ADDR == flow_pkg::OFS_OPT3) begin
        n.opt3 = WDATA;
      end else if (ADDR == flow_pkg::OFS_SC1) begin
        n.sc[0] = WDATA;
      end else if (ADDR == flow_pkg::OFS_SC2) begin
        n.sc[1] = WDATA;
      end else if (ADDR == flow_pkg::OFS_SC3) begin
        n.sc[2] = WDATA;
      end else if (ADDR == flow_pkg::OFS_SC4) begin
        n.sc[3] = WDATA;
      end else if (ADDR == flow_pkg::OFS_FTHR) begin
        n.fthr = WDATA[3:0];
      end else if (ADDR == flow_pkg::OFS_DTHR) begin
        n.dthr = WDATA[3:0];
      end else if (ADDR == flow_pkg::OFS_SPECIAL_TX_COMMAND_REG) begin
        n.special_tx_command_reg = WDATA[3:0];
      end else if (ADDR == flow_pkg::OFS_RIS) begin
        if (WDATA[flow_pkg::RIS_BREAK]) n.brk_stat = 1'b0;
      end else if (ADDR == flow_pkg::OFS_TPR) begin
        n.tick_prescaler = WDATA;
      end else if (ADDR == flow_pkg::OFS_MSV) begin
        n.msv_rts = WDATA[flow_pkg::MSV_RTS];
        n.msv_dtr = WDATA[flow_pkg::MSV_DTR];
      end else if (ADDR == flow_pkg::OFS_DIV) begin
        n.div = WDATA;
      end else if (ADDR == flow_pkg::OFS_CHN) begin
        n.txen = WDATA[flow_pkg::CHN_TXEN];
        n.rxen = WDATA[flow_pkg::CHN_RXEN];
        if (WDATA[flow_pkg::CHN_TXEN] != q.txen) begin
          n.tx_stop   = 1'b0;
          n.tx_resume = 1'b0;
        end
        if (WDATA[flow_pkg::CHN_RXEN] != q.rxen) begin
          n.rx_stop   = 1'b0;
          n.rx_resume = 1'b0;
        end
        if (WDATA[flow_pkg::CHN_RESET]) begin
          // Channel reset drops flags and any half-done escape
          n.tx_stop   = 1'b0;
          n.tx_resume = 1'b0;
          n.rx_stop   = 1'b0;
          n.rx_resume = 1'b0;
          n.special_tx_command_reg      = 4'h0;
          n.esc       = flow_pkg::ESC_IDLE;
          n.brk_req   = 1'b0;
          n.delay     = 8'h00;
          n.in_free   = 1'b1;
          n.in_frame  = 1'b0;
        end
      end
    end

    // Read data stand for one cycle only
    n.rdata = 8'h00;
    if (RD) begin
      if (ADDR == flow_pkg::OFS_OPT2) begin
        n.rdata = q.opt2;
      end else if (ADDR == flow_pkg::OFS_OPT3) begin
        n.rdata = q.opt3;
      end else if (ADDR == flow_pkg::OFS_SC1) begin
        n.rdata = q.sc[0];
      end else if (ADDR == flow_pkg::OFS_SC2) begin
        n.rdata = q.sc[1];
      end else if (ADDR == flow_pkg::OFS_SC3) begin
        n.rdata = q.sc[2];
      end else if (ADDR == flow_pkg::OFS_SC4) begin
        n.rdata = q.sc[3];
      end else if (ADDR == flow_pkg::OFS_FTHR) begin
        n.rdata[3:0] = q.fthr;
      end else if (ADDR == flow_pkg::OFS_DTHR) begin
        n.rdata[3:0] = q.dthr;
      end else if (ADDR == flow_pkg::OFS_SPECIAL_TX_COMMAND_REG) begin
        n.rdata[3:0] = q.special_tx_command_reg;
      end else if (ADDR == flow_pkg::OFS_CSR) begin
        n.rdata[flow_pkg::CSR_RXOFF] = q.rx_stop;
        n.rdata[flow_pkg::CSR_RXON]  = q.rx_resume;
        n.rdata[flow_pkg::CSR_TXOFF] = q.tx_stop;
        n.rdata[flow_pkg::CSR_TXON]  = q.tx_resume;
      end else if (ADDR == flow_pkg::OFS_RIS) begin
        n.rdata[flow_pkg::RIS_BREAK] = q.brk_stat;
      end else if (ADDR == flow_pkg::OFS_TPR) begin
        n.rdata = q.tick_prescaler;
      end else if (ADDR == flow_pkg::OFS_CHN) begin
        n.rdata[flow_pkg::CHN_TXEN] = q.txen;
        n.rdata[flow_pkg::CHN_RXEN] = q.rxen;
      end else if (ADDR == flow_pkg::OFS_MSV) begin
        n.rdata[flow_pkg::MSV_RTS] = q.msv_rts;
        n.rdata[flow_pkg::MSV_DTR] = q.msv_dtr;
        n.rdata[flow_pkg::MSV_CTS] = q.cts2;
        n.rdata[flow_pkg::MSV_DSR] = q.dsr2;
      end else if (ADDR == flow_pkg::OFS_DIV) begin
        n.rdata = q.div;
      end
    end

    // ==========================================================
    // Receive side: flow characters from the remote
    n.rxo_valid = 1'b0;
    if (RX_CHAR_VALID && q.rxen) begin
      if (det_on && !RX_CHAR.err) begin
        if (RX_CHAR.data == q.sc[1]) begin
          is_flow     = 1'b1;
          n.tx_stop   = 1'b1;
          n.tx_resume = 1'b0;
        end else if (RX_CHAR.data == q.sc[0]) begin
          is_flow = 1'b1;
          if (q.tx_stop) begin
            n.tx_stop   = 1'b0;
            n.tx_resume = 1'b1;
          end
        end else if (q.tx_stop && q.opt2[flow_pkg::OPT2_ANY]) begin
          n.tx_stop   = 1'b0;
          n.tx_resume = 1'b1;
        end
      end
      if (!is_flow) n.rx_resume = 1'b0;
      if (!(is_flow && q.opt3[flow_pkg::OPT3_DISCARD])) begin
        n.rxo_valid = 1'b1;
        n.rxo.data  = RX_CHAR.data;
        n.rxo.exc   = is_flow;
      end
    end

    // Break on RXD: flag once per low stretch
    if (!q.rxd2) begin
      if (q.rxlow == ct - 16'h0001) n.brk_stat = 1'b1;
      if (q.rxlow != ct) n.rxlow = q.rxlow + 16'h0001;
    end else begin
      n.rxlow = 16'h0000;
    end

    // Automatic terminal-ready with hysteresis, else plain outputs
    if (q.dthr != 4'h0) begin
      if (RX_FIFO_LEVEL > {1'b0, q.fthr} && RX_FIFO_LEVEL > {1'b0, q.dthr}) begin
        n.dtr_n = 1'b1;
      end else if (RX_FIFO_LEVEL < {1'b0, q.dthr}) begin
        n.dtr_n = 1'b0;
      end
    end else begin
      n.dtr_n = q.msv_dtr;
    end
    n.rts_n = q.msv_rts;

    // ==========================================================
    // Transmit gating; only the holding load is gated, so what is
    // already in holding and shift registers still goes out
    flow_ok = ~(q.tx_stop & det_on);
    cts_ok  = ~q.opt2[flow_pkg::OPT2_CTS] | ~q.cts2;
    if (q.opt2[flow_pkg::OPT2_SYNC] && q.in_frame) cts_ok = 1'b1;
    send_ok = q.txen & flow_ok & cts_ok & ~q.special_tx_command_reg[flow_pkg::SPECIAL_TX_COMMAND_REG_SEND]
            & ~q.brk_req & (q.delay == 8'h00) & ser_ready;

    // Special send ignores every gate but waits for an idle line
    if (q.special_tx_command_reg[flow_pkg::SPECIAL_TX_COMMAND_REG_SEND] && ser_empty) begin
      if (q.special_tx_command_reg[2:0] >= 3'h1 && q.special_tx_command_reg[2:0] <= 3'h4) begin
        ld_valid = 1'b1;
        ld_data  = q.sc[q.special_tx_command_reg[1:0] - 2'h1];
        if (q.special_tx_command_reg[2:0] == 3'h1) begin
          n.rx_resume = 1'b1;
          n.rx_stop   = 1'b0;
        end else if (q.special_tx_command_reg[2:0] == 3'h2) begin
          n.rx_stop   = 1'b1;
          n.rx_resume = 1'b0;
        end
      end
      n.special_tx_command_reg = 4'h0;
    end else if (!q.in_free) begin
      // Host stream and embedded command decoding
      case (q.esc)
        flow_pkg::ESC_IDLE: begin
          if (q.opt2[flow_pkg::OPT2_ETC] && b == flow_pkg::ESC_LEAD) begin
            n.esc     = flow_pkg::ESC_ZERO;
            n.in_free = 1'b1;
          end else if (send_ok) begin
            ld_valid  = 1'b1;
            ld_data   = (q.opt2[flow_pkg::OPT2_ETC] && seven && b == flow_pkg::ESC_NUL7) ? 8'h00 : b;
            n.in_free = 1'b1;
          end
        end
        flow_pkg::ESC_ZERO: begin
          if (b == flow_pkg::ESC_BRK_ON) begin
            n.brk_req  = 1'b1;
            n.brk_done = 1'b0;
            n.brk_cnt  = 16'h0000;
            n.esc      = flow_pkg::ESC_IDLE;
            n.in_free  = 1'b1;
          end else if (b == flow_pkg::ESC_DELAY) begin
            n.esc     = flow_pkg::ESC_COUNT;
            n.in_free = 1'b1;
          end else if (b == flow_pkg::ESC_BRK_OFF) begin
            if (!q.brk_req || q.brk_done) begin
              n.brk_req = 1'b0;
              n.esc     = flow_pkg::ESC_IDLE;
              n.in_free = 1'b1;
            end
          end else if (send_ok) begin
            // Doubled zero sends one NUL; any other code goes out as data
            ld_valid  = 1'b1;
            ld_data   = b;
            n.esc     = flow_pkg::ESC_IDLE;
            n.in_free = 1'b1;
          end
        end
        flow_pkg::ESC_COUNT: begin
          if (ser_empty) begin
            n.delay   = b;
            n.pre     = q.tick_prescaler;
            n.unit    = 16'(TICK_CYCLES - 1);
            n.esc     = flow_pkg::ESC_IDLE;
            n.in_free = 1'b1;
          end
        end
        default: n.esc = flow_pkg::ESC_IDLE;
      endcase
    end

    if (ld_valid && !q.special_tx_command_reg[flow_pkg::SPECIAL_TX_COMMAND_REG_SEND]) begin
      n.tx_resume = 1'b0;
      n.in_frame  = ~q.in_byte.last;
    end
    if (q.in_free && TX_VALID) begin
      n.in_byte = TX_BYTE;
      n.in_free = 1'b0;
    end

    // Minimum break length counts only while the line is low
    if (!q.brk_req) begin
      n.brk_cnt  = 16'h0000;
      n.brk_done = 1'b0;
    end else if (ser_brk && !q.brk_done) begin
      if (q.brk_cnt == ct - 16'h0001) n.brk_done = 1'b1;
      n.brk_cnt = q.brk_cnt + 16'h0001;
    end

    // Delay in ticks of (prescaler + 1) units; line keeps its level
    if (q.delay != 8'h00) begin
      if (q.unit != 16'h0000) begin
        n.unit = q.unit - 16'h0001;
      end else begin
        n.unit = 16'(TICK_CYCLES - 1);
        if (q.pre == 8'h00) begin
          n.pre   = q.tick_prescaler;
          n.delay = q.delay - 8'h01;
        end else begin
          n.pre = q.pre - 8'h01;
        end
      end
    end

    if (SYS_RST) begin
      n         = '0;
      n.tick_prescaler     = flow_pkg::RST_TPR;
      n.opt2    = flow_pkg::RST_REG;
      n.msv_rts = flow_pkg::RST_PIN;
      n.msv_dtr = flow_pkg::RST_PIN;
      n.rts_n   = flow_pkg::RST_PIN;
      n.dtr_n   = flow_pkg::RST_PIN;
      n.cts1    = flow_pkg::RST_PIN;
      n.cts2    = flow_pkg::RST_PIN;
      n.dsr1    = flow_pkg::RST_PIN;
      n.dsr2    = flow_pkg::RST_PIN;
      n.rxd1    = flow_pkg::RST_PIN;
      n.rxd2    = flow_pkg::RST_PIN;
      n.in_free = 1'b1;
      n.esc     = flow_pkg::ESC_IDLE;
    end
  end

  // State register
  always_ff @(posedge MCLK) begin
    q <= n;
  end

  assign cfg.div   = q.div;
  assign cfg.seven = q.opt3[flow_pkg::OPT3_SEVEN];

  // ==========================================================
  // Character engine
  char_shifter u_shifter (
    .clk      (MCLK),
    .rst      (SYS_RST),
    .cfg      (cfg),
    .brk_req  (q.brk_req),
    .ld_valid (ld_valid),
    .ld_data  (ld_data),
    .ld_ready (ser_ready),
    .empty    (ser_empty),
    .txd      (ser_txd),
    .brk_line (ser_brk)
  );

  // Outputs straight from flip-flops
  assign RDATA        = q.rdata;
  assign TX_READY     = q.in_free;
  assign RX_OUT_VALID = q.rxo_valid;
  assign RX_OUT       = q.rxo;
  assign TXD          = ser_txd;
  assign RTS_N        = q.rts_n;
  assign DTR_N        = q.dtr_n;

endmodule : async_flow_control_and_break

// >>> test/flow_props.sv
`timescale 1ns/1ns
module flow_props (
  // Clock and reset
  input wire logic MCLK,
  input wire logic SYS_RST,
  // Register port
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  // Streams
  input wire logic TX_VALID,
  input wire logic TX_READY,
  input wire logic RX_CHAR_VALID,
  input wire flow_pkg::rx_char_type RX_CHAR,
  input wire logic RX_OUT_VALID,
  input wire flow_pkg::rx_out_type RX_OUT,
  // Modem pin
  input wire logic RTS_N
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  // ====================
  // Port relations
  a_rdata_idle: assert property (!RD |=> RDATA == 8'h00) else $error("rdata");
  a_rdata_cause: assert property (RDATA != 8'h00 |-> $past(RD)) else $error("rdata cause");
  a_ready_drop: assert property (TX_VALID && TX_READY |=> !TX_READY) else $error("ready");
  a_ready_stands: assert property (TX_READY && !TX_VALID |=> TX_READY) else $error("ready hold");
  a_out_cause: assert property (RX_OUT_VALID |-> $past(RX_CHAR_VALID)) else $error("out");
  a_out_data: assert property (RX_OUT_VALID |-> RX_OUT.data == $past(RX_CHAR.data)) else $error("data");
  a_exc_clean: assert property (RX_OUT_VALID && RX_OUT.exc |-> !$past(RX_CHAR.err)) else $error("exc");
  a_rts_write: assert property ($changed(RTS_N) |-> $past(WR) || $past(WR, 2)) else $error("rts");
  // Main scenarios reached
  cover property (RX_OUT_VALID && RX_OUT.exc);
  cover property (TX_VALID && TX_READY);
  cover property ($fell(RTS_N));
endmodule : flow_props
bind async_flow_control_and_break flow_props flow_props_i (.*);

// >>> test/remote_term.sv
`timescale 1ns/1ns
module remote_term (
  // Clock
  input wire logic MCLK,
  // Line and controls
  input wire logic TXD,
  input wire logic brk,
  input wire logic hold,
  output logic RXD,
  output logic CTS_N,
  output int low_max
);
  int run = 0;
  // Break on request, else idle mark; clear-to-send withheld on request
  assign RXD = !brk;
  assign CTS_N = hold;
  // Longest low stretch, so a short break cannot hide
  initial low_max = 0;
  always @(posedge MCLK) begin
    run = TXD ? 0 : run + 1;
    if (run > low_max) low_max = run;
  end
endmodule : remote_term

// >>> test/async_flow_control_and_break_tb_top.sv
`timescale 1ns/1ns
module async_flow_control_and_break_tb_top;
  logic MCLK = 0, SYS_RST = 1, WR = 0, RD = 0, TX_VALID = 0, RX_CHAR_VALID = 0, DSR_N = 1, brk = 0, cts = 0;
  logic TX_READY, RX_OUT_VALID, TXD, RTS_N, DTR_N, RXD, CTS_N;
  logic [3:0] ADDR = 4'h0;
  logic [4:0] RX_FIFO_LEVEL = 5'h00;
  logic [7:0] WDATA = 8'h00, RDATA;
  logic [16:0] seed = 17'h1843f;
  flow_pkg::tx_byte_type TX_BYTE = 9'h000;
  flow_pkg::rx_char_type RX_CHAR = 9'h000;
  flow_pkg::rx_out_type RX_OUT;
  int num_errors = 0, comparisons = 0, cyc = 0, low_max;
  // ====================
  // Block and remote end; short tick keeps delays brief
  async_flow_control_and_break #(.TICK_CYCLES(4)) async_flow_control_and_break_i (.*);
  remote_term remote_term_i (.MCLK(MCLK), .TXD(TXD), .brk(brk), .hold(cts), .RXD(RXD), .CTS_N(CTS_N),
                             .low_max(low_max));
  // Clock and hang guard
  always #4 MCLK = ~MCLK;
  always @(posedge MCLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      complete_run();
    end
  end
  // ====================
  // Helpers
  function logic [16:0] lfsr(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction : lfsr
  function logic is_flow(input logic [7:0] d);
    return d == 8'h11 || d == 8'h13;
  endfunction : is_flow
  task chk(input logic [8:0] s, input logic [8:0] e, input string n);
    comparisons++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge MCLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge MCLK);
    WR <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e, input string n);
    @(posedge MCLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge MCLK);
    RD <= 1'b0;
    @(negedge MCLK);
    chk(RDATA & m, e, n);
  endtask : rd
  task rx(input logic [7:0] d, input logic v, input logic x);
    @(posedge MCLK);
    RX_CHAR <= {1'b0, d};
    RX_CHAR_VALID <= 1'b1;
    @(posedge MCLK);
    RX_CHAR_VALID <= 1'b0;
    @(negedge MCLK);
    chk(RX_OUT_VALID, v, "rx valid");
    if (v) chk(RX_OUT, {x, d}, "rx out");
  endtask : rx
  task tx(input logic [7:0] d);
    @(posedge MCLK);
    TX_BYTE <= {1'b0, d};
    TX_VALID <= 1'b1;
    do @(negedge MCLK); while (TX_READY !== 1'b1);
    @(posedge MCLK);
    TX_VALID <= 1'b0;
    @(posedge MCLK);
  endtask : tx
  task complete_run;
    if (num_errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  // ====================
  // Main sequence
  initial begin
    repeat (2) @(posedge MCLK);
    SYS_RST <= 1'b0;
    rd(4'hb, 8'hff, 8'h09, "tpr");
    rd(4'h9, 8'hff, 8'h00, "csr");
    rd(4'hf, 8'hff, 8'h00, "unmapped");
    rd(4'hd, 8'h0f, 8'h0b, "msv");
    wr(4'hd, 8'h00);
    // Pin follows its register bit two edges after the write
    repeat (2) @(negedge MCLK);
    chk({RTS_N, DTR_N}, 2'b00, "pins");
    // Automatic terminal-ready: high above both thresholds, low below its own
    wr(4'h6, 8'h02);
    wr(4'h7, 8'h04);
    RX_FIFO_LEVEL <= 5'h05;
    repeat (2) @(negedge MCLK);
    chk(DTR_N, 1'b1, "dtr high");
    @(posedge MCLK);
    RX_FIFO_LEVEL <= 5'h03;
    repeat (2) @(negedge MCLK);
    chk(DTR_N, 1'b0, "dtr low");
    wr(4'h7, 8'h00);
    wr(4'h2, 8'h11);
    wr(4'h3, 8'h13);
    wr(4'hc, 8'h03);
    wr(4'h1, 8'h10);
    wr(4'h0, 8'h40);
    rx(8'h13, 1'b1, 1'b1);
    rd(4'h9, 8'h06, 8'h04, "stop");
    rx(8'h11, 1'b1, 1'b1);
    rd(4'h9, 8'h06, 8'h02, "resume");
    tx(8'h55);
    repeat (200) @(posedge MCLK);
    rd(4'h9, 8'h06, 8'h00, "restarted");
    wr(4'h1, 8'h30);
    rx(8'h13, 1'b0, 1'b0);
    wr(4'h1, 8'h20);
    rx(8'h11, 1'b1, 1'b0);
    rd(4'h9, 8'h06, 8'h04, "no detect");
    wr(4'hc, 8'h02);
    rd(4'h9, 8'h06, 8'h00, "disable");
    wr(4'h8, 8'h0a);
    repeat (200) @(posedge MCLK);
    rd(4'h8, 8'hff, 8'h00, "special_tx_command_reg");
    rd(4'h9, 8'h10, 8'h10, "rx stop");
    wr(4'h8, 8'h09);
    repeat (200) @(posedge MCLK);
    rd(4'h9, 8'h18, 8'h08, "rx resume");
    rx(8'h41, 1'b1, 1'b0);
    rd(4'h9, 8'h08, 8'h00, "rx next");
    brk <= 1'b1;
    repeat (400) @(posedge MCLK);
    brk <= 1'b0;
    rd(4'ha, 8'h01, 8'h01, "break");
    wr(4'ha, 8'h01);
    rd(4'ha, 8'h01, 8'h00, "break clr");
    wr(4'hc, 8'h03);
    wr(4'h0, 8'h20);
    tx(8'h00);
    tx(8'h81);
    tx(8'h00);
    tx(8'h83);
    repeat (300) @(posedge MCLK);
    chk(low_max >= 10 * 16, 1'b1, "brk len");
    // Inserted delay of 5 ticks of 40 cycles: line high, next byte waits
    tx(8'h00);
    tx(8'h82);
    tx(8'h05);
    tx(8'h41);
    repeat (100) @(negedge MCLK);
    chk({TX_READY, TXD}, 2'b01, "delay hold");
    repeat (150) @(negedge MCLK);
    chk(TX_READY, 1'b1, "delay end");
    // Auto clear-to-send: a byte waits while the remote withholds it
    wr(4'h0, 8'h02);
    cts <= 1'b1;
    tx(8'h41);
    repeat (200) @(negedge MCLK);
    chk({TX_READY, TXD}, 2'b01, "cts hold");
    @(posedge MCLK);
    cts <= 1'b0;
    repeat (200) @(negedge MCLK);
    chk(TX_READY, 1'b1, "cts go");
    // Disabled transmitter takes a byte but loads nothing more
    wr(4'hc, 8'h02);
    tx(8'h42);
    repeat (50) @(negedge MCLK);
    chk(TX_READY, 1'b0, "tx off");
    wr(4'hc, 8'h03);
    repeat (20) @(negedge MCLK);
    chk(TX_READY, 1'b1, "tx on");
    wr(4'h0, 8'h40);
    wr(4'h1, 8'h10);
    repeat (20) begin
      seed = lfsr(seed);
      rx(seed[7:0], 1'b1, is_flow(seed[7:0]));
    end
    complete_run();
  end
endmodule : async_flow_control_and_break_tb_top
